// file: fmd_core_model.sv
`timescale 1ns/10ps
// =========
// Core side: register file and status word
module fmd_core_model (
  // Clock
  input wire logic clk_sys,
  // Instruction from the bench
  input wire logic reqValid,
  input wire logic [15:0] instr,
  input wire logic [15:0] srcOp,
  output fmd_pkg::fmd_req_t req,
  // Results from the unit
  input fmd_pkg::fmd_wb_t wb,
  input fmd_pkg::fmd_stw_t statusWord
);
  logic [15:0] rf_ff [8];
  logic [15:0] stw_ff;
  int nWb_ff = 0;
  int nStw_ff = 0;
  // Operands come already fetched; idle selReg and srcOperand wander so stale values are never trusted
  always_comb begin
    req.valid = reqValid;
    req.instr = instr;
    req.selReg = reqValid ? rf_ff[instr[8:6]] : ~rf_ff[instr[8:6]];
    req.pairReg = rf_ff[instr[8:6] | 3'h1];
    req.srcOperand = reqValid ? srcOp : ~srcOp;
    req.status = stw_ff;
  end
  // Writebacks land in the file and the status word
  always @(posedge clk_sys) begin
    if (wb.valid) begin
      rf_ff[wb.regNum] <= wb.data;
      nWb_ff <= nWb_ff + 1;
    end
    if (statusWord.valid) begin
      stw_ff <= statusWord.word;
      nStw_ff <= nStw_ff + 1;
    end
  end
endmodule : fmd_core_model

// file: fmd_div.sv
`timescale 1ns/10ps
module fmd_div (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Operands
  input wire logic start,
  input wire logic [31:0] dividend,
  input wire logic [15:0] divisor,
  // Result
  output logic done,
  output logic [15:0] quot,
  output logic [15:0] rem,
  output logic zeroDiv,
  output logic tooBig
);
  typedef struct packed {
    fmd_pkg::fmd_div_phase_t phase;
    logic [5:0] cnt;
    logic [31:0] mag;
    logic [15:0] part;
    logic [15:0] dvsr;
    logic negQ;
    logic negR;
    logic done;
    logic [15:0] quot;
    logic [15:0] rem;
    logic zeroDiv;
    logic tooBig;
  } fmd_div_st_t;

  fmd_div_st_t st_ff;
  fmd_div_st_t nxt_st;

  function automatic logic [15:0] neg16(input logic [15:0] v);
    return 16'(~v + 16'h1);
  endfunction : neg16

  // ==========================================================================
  // Restoring divide on magnitudes, one quotient bit per clock
  always_comb begin
    logic [16:0] trial;
    trial = '0;
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    case (st_ff.phase)
      fmd_pkg::DV_IDLE: begin
        if (start) begin
          nxt_st.negQ = dividend[31] ^ divisor[15];
          nxt_st.negR = dividend[31];
          nxt_st.mag = dividend[31] ? 32'(~dividend + 32'h1) : dividend;
          nxt_st.dvsr = divisor[15] ? neg16(divisor) : divisor;
          nxt_st.part = '0;
          nxt_st.cnt = fmd_pkg::DIV_STEPS;
          if (divisor == 16'h0) begin
            // Zero divisor ends at once; quotient and remainder keep old values
            nxt_st.zeroDiv = 1'b1;
            nxt_st.tooBig = 1'b0;
            nxt_st.done = 1'b1;
          end else begin
            nxt_st.zeroDiv = 1'b0;
            nxt_st.phase = fmd_pkg::DV_RUN;
          end
        end
      end
      fmd_pkg::DV_RUN: begin
        trial = {st_ff.part, st_ff.mag[31]};
        nxt_st.mag = {st_ff.mag[30:0], 1'b0};
        if (trial >= {1'b0, st_ff.dvsr}) begin
          nxt_st.part = 16'(trial - {1'b0, st_ff.dvsr});
          nxt_st.mag[0] = 1'b1;
        end else begin
          nxt_st.part = trial[15:0];
        end
        nxt_st.cnt = 6'(st_ff.cnt - 6'h1);
        if (st_ff.cnt == 6'h1) begin
          nxt_st.phase = fmd_pkg::DV_FIN;
        end
      end
      fmd_pkg::DV_FIN: begin
        // Quotient takes the sign of the operands, remainder that of dividend
        nxt_st.quot = st_ff.negQ ? neg16(st_ff.mag[15:0]) : st_ff.mag[15:0];
        nxt_st.rem = st_ff.negR ? neg16(st_ff.part) : st_ff.part;
        nxt_st.tooBig = st_ff.negQ ? (st_ff.mag > fmd_pkg::HALF_RANGE) :
                        (st_ff.mag >= fmd_pkg::HALF_RANGE);
        nxt_st.done = 1'b1;
        nxt_st.phase = fmd_pkg::DV_IDLE;
      end
      default: begin
        nxt_st.phase = fmd_pkg::DV_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_ff <= '0;
      st_ff.phase <= fmd_pkg::DV_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign done = st_ff.done;
  assign quot = st_ff.quot;
  assign rem = st_ff.rem;
  assign zeroDiv = st_ff.zeroDiv;
  assign tooBig = st_ff.tooBig;
endmodule : fmd_div

// file: fmd_flag_ops_muldiv_unit.sv
// Implementation choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module fmd_flag_ops_muldiv_unit (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Instruction request from decode
  input fmd_pkg::fmd_req_t req,
  output logic reqReady,
  // Register writeback and status word update
  output fmd_pkg::fmd_wb_t wb,
  output fmd_pkg::fmd_stw_t statusWord,
  // AXI4-Lite write channels
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read channels
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp
);
  typedef struct packed {
    fmd_pkg::fmd_phase_t phase;
    logic isDiv;
    logic [2:0] sel;
    logic [15:0] status;
    logic [3:0] newFlags;
    logic [15:0] loWord;
    logic [15:0] opA;
    logic [15:0] opB;
    logic [31:0] dividend;
    logic mulStart;
    logic divStart;
    fmd_pkg::fmd_wb_t wb;
    fmd_pkg::fmd_stw_t stw;
    logic awHeld;
    logic [7:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic wLane0;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
    logic ctrlEn;
    logic [15:0] count;
  } fmd_core_st_t;

  fmd_core_st_t st_ff;
  fmd_core_st_t nxt_st;
  logic mulDone;
  logic [31:0] product;
  logic divDone;
  logic [15:0] quot;
  logic [15:0] rem;
  logic divZero;
  logic divBig;

  function automatic logic isCcOp(input logic [15:0] i);
    return i[15:5] == fmd_pkg::CC_MATCH;
  endfunction : isCcOp

  function automatic logic [3:0] packFlags(input logic n, input logic z,
                                           input logic v, input logic c);
    logic [3:0] f;
    f = '0;
    f[fmd_pkg::FLAG_N] = n;
    f[fmd_pkg::FLAG_Z] = z;
    f[fmd_pkg::FLAG_V] = v;
    f[fmd_pkg::FLAG_C] = c;
    return f;
  endfunction : packFlags

  // ==========================================================================
  // Arithmetic units
  fmd_mult u_mult (
    .clk_sys(clk_sys),
    .srst(srst),
    .start(st_ff.mulStart),
    .opA(st_ff.opA),
    .opB(st_ff.opB),
    .done(mulDone),
    .product(product)
  );

  fmd_div u_div (
    .clk_sys(clk_sys),
    .srst(srst),
    .start(st_ff.divStart),
    .dividend(st_ff.dividend),
    .divisor(st_ff.opB),
    .done(divDone),
    .quot(quot),
    .rem(rem),
    .zeroDiv(divZero),
    .tooBig(divBig)
  );

  // ==========================================================================
  // Next state: instruction sequencing and register slave
  always_comb begin
    logic [3:0] mask;
    logic [6:0] opc;
    mask = req.instr[3:0];
    opc = req.instr[15:9];
    nxt_st = st_ff;
    nxt_st.wb.valid = 1'b0;
    nxt_st.stw.valid = 1'b0;
    nxt_st.mulStart = 1'b0;
    nxt_st.divStart = 1'b0;
    case (st_ff.phase)
      fmd_pkg::PH_IDLE: begin
        if (req.valid) begin
          nxt_st.sel = req.instr[fmd_pkg::SEL_LSB +: 3];
          nxt_st.status = req.status;
          nxt_st.opB = req.srcOperand;
          if (isCcOp(req.instr)) begin
            // Upper status bits and unmasked flags pass straight through
            nxt_st.stw.valid = 1'b1;
            nxt_st.stw.word[15:4] = req.status[15:4];
            if (req.instr[fmd_pkg::CC_SET_BIT]) begin
              nxt_st.stw.word[3:0] = req.status[3:0] | mask;
            end else begin
              nxt_st.stw.word[3:0] = req.status[3:0] & ~mask;
            end
            nxt_st.count = 16'(st_ff.count + 16'h1);
          end else if (st_ff.ctrlEn && opc == fmd_pkg::OPC_PRODUCT) begin
            nxt_st.opA = req.selReg;
            nxt_st.mulStart = 1'b1;
            nxt_st.isDiv = 1'b0;
            nxt_st.phase = fmd_pkg::PH_MUL;
          end else if (st_ff.ctrlEn && opc == fmd_pkg::OPC_DIVIDE) begin
            // Pair register comes from number OR 1; odd numbers are not checked
            nxt_st.dividend = {req.selReg, req.pairReg};
            nxt_st.divStart = 1'b1;
            nxt_st.isDiv = 1'b1;
            nxt_st.phase = fmd_pkg::PH_DIV;
          end
        end
      end
      fmd_pkg::PH_MUL: begin
        if (mulDone) begin
          nxt_st.wb = '{valid: 1'b1, regNum: st_ff.sel, data: product[31:16]};
          nxt_st.loWord = product[15:0];
          nxt_st.newFlags = packFlags(product[31], product == 32'h0, 1'b0,
                                      product[31:15] != {17{product[31]}});
          nxt_st.phase = fmd_pkg::PH_WBLO;
        end
      end
      fmd_pkg::PH_DIV: begin
        if (divDone) begin
          nxt_st.wb = '{valid: 1'b1, regNum: st_ff.sel, data: quot};
          nxt_st.loWord = rem;
          nxt_st.newFlags = packFlags(quot[15], quot == 16'h0 && !divBig,
                                      divZero | divBig, divZero);
          nxt_st.phase = fmd_pkg::PH_WBLO;
        end
      end
      fmd_pkg::PH_WBLO: begin
        // Odd register on a product: second write lands on the same register
        nxt_st.wb = '{valid: 1'b1, regNum: st_ff.sel | 3'h1, data: st_ff.loWord};
        nxt_st.stw = '{valid: 1'b1, word: {st_ff.status[15:4], st_ff.newFlags}};
        nxt_st.count = 16'(st_ff.count + 16'h1);
        nxt_st.phase = fmd_pkg::PH_IDLE;
      end
      default: begin
        nxt_st.phase = fmd_pkg::PH_IDLE;
      end
    endcase

    // Write address and data may arrive in either order
    if (awvalid && awready) begin
      nxt_st.awHeld = 1'b1;
      nxt_st.awAddr = awaddr;
    end
    if (wvalid && wready) begin
      nxt_st.wHeld = 1'b1;
      nxt_st.wData = wdata;
      nxt_st.wLane0 = wstrb[0];
    end
    if (st_ff.awHeld && st_ff.wHeld) begin
      nxt_st.awHeld = 1'b0;
      nxt_st.wHeld = 1'b0;
      nxt_st.bValid = 1'b1;
      nxt_st.bResp = fmd_pkg::RESP_OKAY;
      if (st_ff.awAddr == fmd_pkg::ADDR_CTRL) begin
        if (st_ff.wLane0) begin
          nxt_st.ctrlEn = st_ff.wData[0];
        end
      end else if (st_ff.awAddr == fmd_pkg::ADDR_STATUS) begin
        nxt_st.bResp = fmd_pkg::RESP_OKAY;
      end else if (st_ff.awAddr == fmd_pkg::ADDR_COUNT) begin
        nxt_st.bResp = fmd_pkg::RESP_OKAY;
      end else begin
        nxt_st.bResp = fmd_pkg::RESP_SLVERR;
      end
    end
    if (st_ff.bValid && bready) begin
      nxt_st.bValid = 1'b0;
    end

    // Read decode; unmapped words answer zero with an error
    if (arvalid && arready) begin
      nxt_st.rValid = 1'b1;
      nxt_st.rResp = fmd_pkg::RESP_OKAY;
      if (araddr == fmd_pkg::ADDR_CTRL) begin
        nxt_st.rData = {31'h0, st_ff.ctrlEn};
      end else if (araddr == fmd_pkg::ADDR_STATUS) begin
        nxt_st.rData = {15'h0, st_ff.phase != fmd_pkg::PH_IDLE, st_ff.stw.word};
      end else if (araddr == fmd_pkg::ADDR_COUNT) begin
        nxt_st.rData = {16'h0, st_ff.count};
      end else begin
        nxt_st.rData = '0;
        nxt_st.rResp = fmd_pkg::RESP_SLVERR;
      end
    end else if (st_ff.rValid && rready) begin
      nxt_st.rValid = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_ff <= '0;
      st_ff.phase <= fmd_pkg::PH_IDLE;
      st_ff.ctrlEn <= fmd_pkg::CTRL_EN_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================================
  // Outputs
  assign reqReady = st_ff.phase == fmd_pkg::PH_IDLE;
  assign wb = st_ff.wb;
  assign statusWord = st_ff.stw;
  assign awready = !st_ff.awHeld && !st_ff.bValid;
  assign wready = !st_ff.wHeld && !st_ff.bValid;
  assign bvalid = st_ff.bValid;
  assign bresp = st_ff.bResp;
  assign arready = !st_ff.rValid;
  assign rvalid = st_ff.rValid;
  assign rdata = st_ff.rData;
  assign rresp = st_ff.rResp;

  // ==========================================================================
  // Checks
  logic accCc;
  logic accMul;
  logic mulFin;
  logic divFin;
  logic signed [31:0] mulRef;
  assign accCc = req.valid && reqReady && isCcOp(req.instr);
  assign accMul = req.valid && reqReady && !isCcOp(req.instr) && st_ff.ctrlEn &&
                  req.instr[15:9] == fmd_pkg::OPC_PRODUCT;
  assign mulFin = st_ff.phase == fmd_pkg::PH_WBLO && !st_ff.isDiv;
  assign divFin = st_ff.phase == fmd_pkg::PH_WBLO && st_ff.isDiv;
  assign mulRef = $signed({{16{req.selReg[15]}}, req.selReg}) *
                  $signed({{16{req.srcOperand[15]}}, req.srcOperand});

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  property p_cc_clear;
    accCc && !req.instr[4] |=> statusWord.valid &&
      statusWord.word[3:0] == ($past(req.status[3:0]) & ~$past(req.instr[3:0]));
  endproperty
  a_cc_clear: assert property (p_cc_clear) else $error("flag clear wrong");

  property p_cc_set;
    accCc && req.instr[4] |=> statusWord.valid &&
      statusWord.word[3:0] == ($past(req.status[3:0]) | $past(req.instr[3:0]));
  endproperty
  a_cc_set: assert property (p_cc_set) else $error("flag set wrong");

  property p_cc_keep;
    accCc |=> statusWord.word[15:4] == $past(req.status[15:4]) && !wb.valid;
  endproperty
  a_cc_keep: assert property (p_cc_keep) else $error("status upper bits changed");

  property p_mul_sel;
    accMul |-> ##3 (wb.valid && wb.regNum == $past(req.instr[8:6], 3));
  endproperty
  a_mul_sel: assert property (p_mul_sel) else $error("register field misdecoded");

  property p_mul_prod;
    accMul |-> ##2 (mulDone && product == $past(mulRef, 2));
  endproperty
  a_mul_prod: assert property (p_mul_prod) else $error("product wrong");

  property p_mul_zn;
    mulFin |=> statusWord.word[fmd_pkg::FLAG_Z] == (product == 32'h0) &&
      statusWord.word[fmd_pkg::FLAG_N] == product[31];
  endproperty
  a_mul_zn: assert property (p_mul_zn) else $error("product Z or N wrong");

  property p_mul_cv;
    mulFin |=> !statusWord.word[fmd_pkg::FLAG_V] &&
      statusWord.word[fmd_pkg::FLAG_C] == ($signed(product) < -32'sd32768 ||
                                            $signed(product) >= 32'sd32768);
  endproperty
  a_mul_cv: assert property (p_mul_cv) else $error("product C or V wrong");

  property p_hi_write;
    st_ff.phase == fmd_pkg::PH_MUL && mulDone |=> wb.valid &&
      wb.data == product[31:16] && wb.regNum == st_ff.sel;
  endproperty
  a_hi_write: assert property (p_hi_write) else $error("high half write wrong");

  property p_lo_write;
    st_ff.phase == fmd_pkg::PH_WBLO |=> wb.valid && statusWord.valid &&
      wb.regNum == ($past(st_ff.sel) | 3'h1) &&
      wb.data == ($past(st_ff.isDiv) ? rem : product[15:0]);
  endproperty
  a_lo_write: assert property (p_lo_write) else $error("pair write wrong");

  property p_div_quot;
    st_ff.phase == fmd_pkg::PH_DIV && divDone |=> wb.valid && wb.data == quot &&
      wb.regNum == st_ff.sel;
  endproperty
  a_div_quot: assert property (p_div_quot) else $error("quotient write wrong");

  property p_div_flags;
    divFin |=> statusWord.word[fmd_pkg::FLAG_N] == quot[15] &&
      statusWord.word[fmd_pkg::FLAG_Z] == (quot == 16'h0 && !divBig) &&
      statusWord.word[fmd_pkg::FLAG_C] == divZero &&
      statusWord.word[fmd_pkg::FLAG_V] == (divZero || divBig);
  endproperty
  a_div_flags: assert property (p_div_flags) else $error("divide flags wrong");

  c_cc_op: cover property (accCc ##1 statusWord.valid);
  c_mul_done: cover property (mulFin ##1 wb.valid);
  c_div_zero: cover property (divFin && divZero);
  c_div_big: cover property (divFin && divBig);
endmodule : fmd_flag_ops_muldiv_unit

// file: fmd_mult.sv
`timescale 1ns/10ps
module fmd_mult (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Operands
  input wire logic start,
  input wire logic [15:0] opA,
  input wire logic [15:0] opB,
  // Result
  output logic done,
  output logic [31:0] product
);
  typedef struct packed {
    logic done;
    logic [31:0] prod;
  } fmd_mult_st_t;

  fmd_mult_st_t st_ff;
  fmd_mult_st_t nxt_st;
  logic signed [31:0] extA;
  logic signed [31:0] extB;

  // Sign extension makes the low 32 bits of the product exact
  always_comb begin
    extA = {{16{opA[15]}}, opA};
    extB = {{16{opB[15]}}, opB};
    nxt_st = st_ff;
    nxt_st.done = start;
    if (start) begin
      nxt_st.prod = extA * extB;
    end
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign done = st_ff.done;
  assign product = st_ff.prod;
endmodule : fmd_mult

// file: fmd_pkg.sv
package fmd_pkg;
  // ==========================================================================
  // Instruction decode
  localparam logic [10:0] CC_MATCH = 11'h005;
  localparam logic [6:0] OPC_PRODUCT = 7'h38;
  localparam logic [6:0] OPC_DIVIDE = 7'h39;
  localparam int CC_SET_BIT = 4;
  localparam int SEL_LSB = 6;
  localparam int FLAG_C = 0;
  localparam int FLAG_V = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_N = 3;
  localparam logic [31:0] HALF_RANGE = 32'h0000_8000;
  localparam logic [5:0] DIV_STEPS = 6'h20;

  // ==========================================================================
  // Register map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_COUNT = 8'h08;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Types
  typedef enum logic [3:0] {
    PH_IDLE = 4'h1,
    PH_MUL = 4'h2,
    PH_DIV = 4'h4,
    PH_WBLO = 4'h8
  } fmd_phase_t;

  typedef enum logic [2:0] {
    DV_IDLE = 3'h1,
    DV_RUN = 3'h2,
    DV_FIN = 3'h4
  } fmd_div_phase_t;

  typedef struct packed {
    logic valid;
    logic [15:0] instr;
    logic [15:0] selReg;
    logic [15:0] pairReg;
    logic [15:0] srcOperand;
    logic [15:0] status;
  } fmd_req_t;

  typedef struct packed {
    logic valid;
    logic [2:0] regNum;
    logic [15:0] data;
  } fmd_wb_t;

  typedef struct packed {
    logic valid;
    logic [15:0] word;
  } fmd_stw_t;
endpackage : fmd_pkg

// file: test_flag_ops_and_muldiv_unit.sv
`timescale 1ns/10ps
module test_flag_ops_and_muldiv_unit;
  // =========
  // Stimulus and observed signals
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic reqValid = 1'b0;
  logic [15:0] instr = 16'h0000;
  logic [15:0] srcOp = 16'h0000;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic reqReady, awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdata, d, r;
  fmd_pkg::fmd_req_t req;
  fmd_pkg::fmd_wb_t wb;
  fmd_pkg::fmd_stw_t statusWord;
  int mismatches = 0;
  int n_checks = 0;
  int seed = 32'h1bef;
  int n;
  logic [15:0] e [8];
  logic [15:0] eStw, lq, lr;
  int nOps = 0;
  logic [3:0] cm [5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'hf};
  // Corner table: {div, sel}, dividend or operand, source
  logic [51:0] cx [12] = '{52'h2_00000080_0100, 52'h5_00007fff_0001, 52'h0_00008000_0001,
    52'h3_00000003_d555, 52'h6_00001234_0000, 52'h7_00008000_8000, 52'hc_00010000_0002,
    52'ha_ffff0000_0002, 52'he_00000007_fffe, 52'h8_fffffff9_0002, 52'hc_00000005_0007,
    52'ha_00001234_0000};
  always #25 clk_sys = ~clk_sys;
  fmd_flag_ops_muldiv_unit dut (.clk_sys(clk_sys), .srst(srst), .req(req), .reqReady(reqReady),
    .wb(wb), .statusWord(statusWord), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));
  fmd_core_model p (.clk_sys(clk_sys), .reqValid(reqValid), .instr(instr), .srcOp(srcOp),
    .req(req), .wb(wb), .statusWord(statusWord));
  // =========
  // Checking and closing
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic end_of_test();
    if (mismatches == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test
  // =========
  // Register bus master; it never assumes how soon the slave answers
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    bit ad, wd;
    ad = 0;
    wd = 0;
    n = 0;
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= v;
    wstrb <= 4'hf;
    while (!(ad && wd) && n < 100) begin
      @(posedge clk_sys);
      n++;
      if (awvalid && awready) begin
        ad = 1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        wd = 1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (!bvalid && n < 200);
    rs = bresp;
    bready <= 1'b0;
    if (n > 199) mismatches++;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    n = 0;
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (!(arvalid && arready) && n < 100);
    arvalid <= 1'b0;
    while (!(rvalid && rready) && n < 200) begin
      @(posedge clk_sys);
      n++;
    end
    d = rdata;
    rs = rresp;
    rready <= 1'b0;
    if (n > 199) mismatches++;
  endtask : rd
  // =========
  // Instruction port; an ignored word has no completion, so a span longer than a divide passes
  task automatic issue(input logic [15:0] ins, input logic [15:0] src, input bit ign);
    int b4;
    b4 = p.nStw_ff;
    n = 0;
    reqValid <= 1'b1;
    instr <= ins;
    srcOp <= src;
    do begin
      @(posedge clk_sys);
      n++;
    end while (!reqReady && n < 100);
    reqValid <= 1'b0;
    instr <= 16'($random(seed));
    if (ign) repeat (40) @(posedge clk_sys);
    while (!ign && p.nStw_ff == b4 && n < 200) begin
      @(posedge clk_sys);
      n++;
    end
    if (n > 199) mismatches++;
  endtask : issue
  task automatic sr(input int i, input logic [15:0] v);
    p.rf_ff[i] = v;
    e[i] = v;
  endtask : sr
  task automatic cc(input logic [4:0] lo);
    issue({fmd_pkg::CC_MATCH, lo}, 16'($random(seed)), 0);
    eStw = lo[4] ? eStw | lo[3:0] : eStw & ~{12'h0, lo[3:0]};
    check("status", p.stw_ff, eStw);
    nOps++;
  endtask : cc
  // Expected flags and writebacks of one extended operation
  task automatic ext(input logic dv, input logic [2:0] s, input logic [15:0] b);
    logic signed [63:0] x, q, m;
    logic [3:0] f;
    logic [15:0] hi, lo;
    if (!dv) begin
      q = $signed(e[s]) * $signed(b);
      f = {q[31], q == 0, 1'b0, q < -32768 || q > 32767};
      hi = q[31:16];
      lo = q[15:0];
    end else if (b == 16'h0) begin
      // Divider keeps its last results, so N and Z follow the old quotient
      f = {lq[15], lq == 16'h0, 1'b1, 1'b1};
      hi = lq;
      lo = lr;
    end else begin
      x = $signed({e[s], e[s | 3'h1]});
      q = x / $signed(b);
      m = x % $signed(b);
      f = {q[15], q == 0, q < -32768 || q > 32767, 1'b0};
      hi = q[15:0];
      lo = m[15:0];
      lq = hi;
      lr = lo;
    end
    issue({dv ? fmd_pkg::OPC_DIVIDE : fmd_pkg::OPC_PRODUCT, s, 6'($random(seed))}, b, 0);
    if (dv) check("div flags", p.stw_ff[3:0], f);
    else check("mul flags", p.stw_ff[3:0], f);
    eStw[3:0] = f;
    nOps++;
    e[s] = hi;
    e[s | 3'h1] = lo;
    for (int i = 0; i < 8; i++) check("reg", p.rf_ff[i], e[i]);
  endtask : ext
  // =========
  // Main sequence
  initial begin
    repeat (16) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    for (int i = 0; i < 8; i++) sr(i, 16'($random(seed)));
    eStw = 16'($random(seed));
    p.stw_ff = eStw;
    rd(fmd_pkg::ADDR_CTRL);
    check("ctrl", d & 32'h1, 32'h1);
    rd(8'h0c);
    check("bad resp", rs, fmd_pkg::RESP_SLVERR);
    check("bad data", d, 32'h0);
    foreach (cx[k]) begin
      if (cx[k][51]) sr(cx[k][50:48], cx[k][47:32]);
      sr(cx[k][51] ? cx[k][50:48] | 3'h1 : cx[k][50:48], cx[k][31:16]);
      ext(cx[k][51], cx[k][50:48], cx[k][15:0]);
    end
    for (int k = 0; k < 10; k++) cc({k < 5, cm[k % 5]});
    cc(5'h10);
    wr(fmd_pkg::ADDR_STATUS, 32'h0);
    check("ro resp", rs, fmd_pkg::RESP_OKAY);
    wr(8'h0c, 32'h0);
    check("bad wr resp", rs, fmd_pkg::RESP_SLVERR);
    rd(fmd_pkg::ADDR_STATUS);
    check("status reg", d[15:0], eStw);
    check("busy", d[31:16], 32'h0);
    // Disabled extended ops and foreign words must leave no trace
    wr(fmd_pkg::ADDR_CTRL, 32'h0);
    n = p.nWb_ff + p.nStw_ff;
    r = n;
    issue({fmd_pkg::OPC_PRODUCT, 9'h0c1}, 16'h0003, 1);
    issue(16'h0000, 16'h0003, 1);
    check("ignored", p.nWb_ff + p.nStw_ff, r);
    wr(fmd_pkg::ADDR_CTRL, 32'h1);
    // Random mix; divides use an even register
    repeat (60) begin
      r = $random(seed);
      if (r[1:0] == 2'h0) cc(r[8:4]);
      else ext(r[1], r[11:9] & {2'h3, ~r[1]}, r[31:16]);
    end
    // Every flag op and every finished extended op counts once
    rd(fmd_pkg::ADDR_COUNT);
    check("count", d, nOps);
    end_of_test();
  end
  // Watchdog well beyond the longest run
  initial begin
    #(50 * 30000);
    mismatches++;
    end_of_test();
  end
endmodule : test_flag_ops_and_muldiv_unit
